// *** pkg/np_tx_pkg.sv ***
// Package with register map, field layout and reset values of the next page block.
package np_tx_pkg;
   // ==========================================================
   // Register byte addresses (management index times four).
   localparam logic [7:0]  NPTX_INDEX      = 8'h07;
   localparam logic [7:0]  EXP_INDEX       = 8'h06;
   localparam logic [7:0]  ARB_INDEX       = 8'h40;
   localparam logic [31:0] NPTX_ADDR       = {22'h0, NPTX_INDEX, 2'b00};
   localparam logic [31:0] EXP_ADDR        = {22'h0, EXP_INDEX, 2'b00};
   localparam logic [31:0] ARB_ADDR        = {22'h0, ARB_INDEX, 2'b00};
   // ==========================================================
   // Field positions of the next page transmit register.
   localparam int          MORE_POS        = 15;
   localparam int          RSVD_POS        = 14;
   localparam int          MSG_POS         = 13;
   localparam int          COMPLY_POS      = 12;
   localparam int          TOGGLE_POS      = 11;
   localparam int          CODE_MSB        = 10;
   localparam int          CAPABLE_POS     = 2;
   // ==========================================================
   // Reset values.
   localparam logic        MORE_RESET      = 1'b0;
   localparam logic        MSG_RESET       = 1'b1;
   localparam logic        COMPLY_RESET    = 1'b0;
   localparam logic        TOGGLE_RESET    = 1'b0;
   localparam logic [10:0] CODE_RESET      = 11'h001;
   // Arbitration control register: bit 0 enables the page exchange.
   localparam int          ARB_EN_POS      = 0;
   // AXI responses.
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage : np_tx_pkg

// *** hw/np_toggle_arb.sv ***
// Toggle keeper of the arbitration function for next page exchange.
`timescale 1ns/1ps
module np_toggle_arb (
   input  wire logic i_clock,          // System clock.
   input  wire logic i_rst,            // Asynchronous reset, active high.
   input  wire logic i_word_sent,      // Pulse: link code word exchanged.
   input  wire logic i_sent_toggle,    // Toggle bit of the word exchanged.
   output logic      o_page_toggle_bit // Toggle for the next page.
);
   import np_tx_pkg::*;
   typedef struct packed {
      logic toggle;
   } arb_state_t;
   arb_state_t state_reg;
   arb_state_t state_next;

   // ==========================================================
   // Next state: invert the toggle of the last exchanged word.
   always_comb begin
      state_next = state_reg;
      if (i_word_sent) begin
         state_next.toggle = ~i_sent_toggle;
      end
   end

   // Register the state.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_reg.toggle <= TOGGLE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_page_toggle_bit = state_reg.toggle;
endmodule : np_toggle_arb

// *** hw/np_tx_regs.sv ***
// Next page transmit register bank with an AXI4-Lite slave port.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Contract
// - The next page transmit register sits at management index 0x07 and supplies the transmitted next page.
// - Bit 15 is a read-write more-pages flag resetting to 0.
// - Bit 14 is reserved, ignores writes and reads as zero.
// - Bit 13 is a read-write message page select resetting to 1.
// - Bit 12 is a read-write will-comply flag resetting to 0.
// - Bit 11 is a read-only toggle kept as the inverse of the last exchanged word's toggle, resetting to 0.
// - Bits 10 to 0 are a read-write code field resetting to the null page 0x001.
// - The expansion status register reports a constant 1 in its capable bit.
module np_tx_regs (
   input  wire logic        i_clock,         // 10 MHz system clock.
   input  wire logic        i_rst,           // Async reset, active high.
   input  wire logic [31:0] i_awaddr,        // Write address.
   input  wire logic        i_awvalid,       // Write address valid.
   output logic             o_awready,       // Write address ready.
   input  wire logic [31:0] i_wdata,         // Write data.
   input  wire logic [3:0]  i_wstrb,         // Write byte strobes.
   input  wire logic        i_wvalid,        // Write data valid.
   output logic             o_wready,        // Write data ready.
   output logic [1:0]       o_bresp,         // Write response.
   output logic             o_bvalid,        // Write response valid.
   input  wire logic        i_bready,        // Write response ready.
   input  wire logic [31:0] i_araddr,        // Read address.
   input  wire logic        i_arvalid,       // Read address valid.
   output logic             o_arready,       // Read address ready.
   output logic [31:0]      o_rdata,         // Read data.
   output logic [1:0]       o_rresp,         // Read response.
   output logic             o_rvalid,        // Read data valid.
   input  wire logic        i_rready,        // Read data ready.
   input  wire logic        i_word_sent,     // Pulse: word exchanged.
   input  wire logic        i_sent_toggle,   // Toggle of exchanged word.
   output logic [15:0]      o_next_page,     // Page offered to arbitration.
   output logic             o_exchange_en    // Next page exchange enable.
);
   import np_tx_pkg::*;

   typedef struct packed {
      logic        aw_full;
      logic [31:0] aw_addr;
      logic        w_full;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        more;
      logic        msg;
      logic        comply;
      logic [10:0] code;
      logic        arb_en;
   } regs_state_t;

   regs_state_t state_reg;
   regs_state_t state_next;
   logic        toggle;

   // Word-aligned address decode, used by both read and write paths.
   function automatic logic [1:0] decode(input logic [31:0] addr);
      if (addr == NPTX_ADDR) begin
         decode = 2'd1;
      end else if (addr == EXP_ADDR) begin
         decode = 2'd2;
      end else if (addr == ARB_ADDR) begin
         decode = 2'd3;
      end else begin
         decode = 2'd0;
      end
   endfunction : decode

   // ==========================================================
   // Toggle keeper; software has no write path into it.
   np_toggle_arb u_arb (
      .i_clock           (i_clock),
      .i_rst             (i_rst),
      .i_word_sent       (i_word_sent),
      .i_sent_toggle     (i_sent_toggle),
      .o_page_toggle_bit (toggle)
   );

   // Handshake outputs: a channel is ready while its holding slot is empty and, for the write channels, no bvalid is pending.
   assign o_awready = ~state_reg.aw_full & ~state_reg.bvalid;
   assign o_wready  = ~state_reg.w_full & ~state_reg.bvalid;
   assign o_arready = ~state_reg.rvalid;
   assign o_bvalid  = state_reg.bvalid;
   assign o_bresp   = state_reg.bresp;
   assign o_rvalid  = state_reg.rvalid;
   assign o_rresp   = state_reg.rresp;
   assign o_rdata   = state_reg.rdata;
   assign o_exchange_en = state_reg.arb_en;

   assign o_next_page = {state_reg.more, 1'b0, state_reg.msg,
                         state_reg.comply, toggle, state_reg.code};

   // ==========================================================
   // Bus and register next-state logic.
   always_comb begin
      logic [1:0]  wsel;
      logic [1:0]  rsel;
      logic        do_write;
      wsel     = 2'd0;
      rsel     = 2'd0;
      do_write = 1'b0;
      state_next = state_reg;

      // Address and data are taken in either order and held.
      if (i_awvalid && o_awready) begin
         state_next.aw_full = 1'b1;
         state_next.aw_addr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         state_next.w_full = 1'b1;
         state_next.w_data = i_wdata;
         state_next.w_strb = i_wstrb;
      end

      // Write commits once both halves are held.
      if (state_reg.aw_full && state_reg.w_full) begin
         wsel = decode(state_reg.aw_addr);
         do_write = 1'b1;
         state_next.aw_full = 1'b0;
         state_next.w_full  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = (wsel == 2'd0) ? RESP_SLVERR : RESP_OKAY;
      end else if (state_reg.bvalid && i_bready) begin
         state_next.bvalid = 1'b0;
      end

      if (do_write && wsel == 2'd1) begin
         if (state_reg.w_strb[0]) begin
            state_next.code[7:0] = state_reg.w_data[7:0];
         end
         // The toggle and reserved bits take no write.
         if (state_reg.w_strb[1]) begin
            state_next.more   = state_reg.w_data[MORE_POS];
            state_next.msg    = state_reg.w_data[MSG_POS];
            state_next.comply = state_reg.w_data[COMPLY_POS];
            state_next.code[CODE_MSB:8] = state_reg.w_data[CODE_MSB:8];
         end
      end
      if (do_write && wsel == 2'd3 && state_reg.w_strb[0]) begin
         state_next.arb_en = state_reg.w_data[ARB_EN_POS];
      end

      // Read answers one cycle after the address is taken.
      if (i_arvalid && o_arready) begin
         rsel = decode(i_araddr);
         state_next.rvalid = 1'b1;
         state_next.rresp  = (rsel == 2'd0) ? RESP_SLVERR : RESP_OKAY;
         case (rsel)
            2'd1: begin
               state_next.rdata = {16'h0000, o_next_page};
            end
            2'd2: begin
               state_next.rdata = 32'h0000_0000;
               state_next.rdata[CAPABLE_POS] = 1'b1;
            end
            2'd3: begin
               state_next.rdata = {31'h0, state_reg.arb_en};
            end
            default: begin
               state_next.rdata = 32'h0000_0000;
            end
         endcase
      end else if (state_reg.rvalid && i_rready) begin
         state_next.rvalid = 1'b0;
      end
   end

   // ==========================================================
   // State register with reset values.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_reg.aw_full <= 1'b0;
         state_reg.aw_addr <= 32'h0000_0000;
         state_reg.w_full  <= 1'b0;
         state_reg.w_data  <= 32'h0000_0000;
         state_reg.w_strb  <= 4'h0;
         state_reg.bvalid  <= 1'b0;
         state_reg.bresp   <= RESP_OKAY;
         state_reg.rvalid  <= 1'b0;
         state_reg.rresp   <= RESP_OKAY;
         state_reg.rdata   <= 32'h0000_0000;
         state_reg.more    <= MORE_RESET;
         state_reg.msg     <= MSG_RESET;
         state_reg.comply  <= COMPLY_RESET;
         state_reg.code    <= CODE_RESET;
         state_reg.arb_en  <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule : np_tx_regs

// *** verif/np_tx_props.sv ***
// Checker of the next page register bank, seen at its ports.
`timescale 1ns/1ps
module np_tx_props (
   input wire logic        i_clock,     // Clock.
   input wire logic        i_rst,       // Reset.
   input wire logic        o_awready,   // Aw ready.
   input wire logic        o_wready,    // W ready.
   input wire logic [1:0]  o_bresp,     // Write response.
   input wire logic        o_bvalid,    // Write response valid.
   input wire logic        i_bready,    // Write response ready.
   input wire logic        i_arvalid,   // Ar valid.
   input wire logic        o_arready,   // Ar ready.
   input wire logic [31:0] o_rdata,     // Read data.
   input wire logic        o_rvalid,    // Read valid.
   input wire logic        i_rready,    // Read ready.
   input wire logic        i_word_sent, // Word exchanged.
   input wire logic        i_sent_toggle, // Toggle of that word.
   input wire logic [15:0] o_next_page  // Offered page.
);
   // ==========================================================
   // Properties, all in the one clock domain.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   chk_rsvd_zero: assert property (o_next_page[14] == 1'b0)
      else $error("reserved page bit set");
   chk_rsvd_read: assert property (o_rvalid |-> o_rdata[14] == 1'b0)
      else $error("reserved bit read as one");
   chk_toggle_flip: assert property (i_word_sent |=>
      o_next_page[11] == !$past(i_sent_toggle))
      else $error("toggle not inverted");
   chk_toggle_hold: assert property (!i_word_sent |=>
      $stable(o_next_page[11]))
      else $error("toggle moved without exchange");
   chk_page_cause: assert property ($changed(o_next_page[15:12]) ||
      $changed(o_next_page[10:0]) |-> o_bvalid || $past(o_bvalid))
      else $error("page changed without write");
   chk_read_answer: assert property (i_arvalid && o_arready |=>
      o_rvalid) else $error("read not answered");
   chk_bresp_hold: assert property (o_bvalid && !i_bready |=>
      o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
   chk_rdata_hold: assert property (o_rvalid && !i_rready |=>
      o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
   chk_wr_refuse: assert property (o_bvalid |->
      !o_awready && !o_wready) else $error("write taken while busy");
   cov_exchange: cover property (i_word_sent ##1 o_next_page[11]);
   cov_write: cover property (o_bvalid && i_bready);
   cov_read: cover property (o_rvalid && i_rready);
endmodule : np_tx_props
bind np_tx_regs np_tx_props u_props (.i_clock, .i_rst, .o_awready,
   .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready,
   .o_rdata, .o_rvalid, .i_rready, .i_word_sent, .i_sent_toggle,
   .o_next_page);

// *** verif/np_link_partner.sv ***
// Behavioural arbitration side that reports exchanged link code words.
`timescale 1ns/1ps
module np_link_partner (
   input  wire logic i_clock,      // System clock.
   output logic      o_word_sent,  // Pulse: word exchanged.
   output logic      o_sent_toggle // Toggle of exchanged word.
);
   initial begin
      o_word_sent = 1'b0;
      o_sent_toggle = 1'b1;
   end
   // One pulse; the toggle line is not held after it, so it turns over.
   task automatic exchange(input logic t);
      o_word_sent <= 1'b1;
      o_sent_toggle <= t;
      @(posedge i_clock);
      o_word_sent <= 1'b0;
      o_sent_toggle <= ~t;
   endtask : exchange
endmodule : np_link_partner

// *** verif/np_tx_regs_bench.sv ***
// Testbench of the next page transmit register bank.
`timescale 1ns/1ps
module np_tx_regs_bench;
   import np_tx_pkg::*;
   logic        clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0;
   logic        rready = 0, aw_rdy, w_rdy, bv, ar_rdy, rv, ws, st, en;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
   logic [3:0]  wstrb = 0;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] page;
   int          miscompares = 0, check_count = 0;
   // ==========================================================
   // Clock, design and partner.
   initial begin
      forever #50 clk = ~clk;
   end
   np_tx_regs u_dut (.i_clock(clk), .i_rst(rst), .i_awaddr(awaddr),
      .i_awvalid(awv), .o_awready(aw_rdy), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wv), .o_wready(w_rdy), .o_bresp(bresp), .o_bvalid(bv),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arv),
      .o_arready(ar_rdy), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
      .i_rready(rready), .i_word_sent(ws), .i_sent_toggle(st),
      .o_next_page(page), .o_exchange_en(en));
   np_link_partner u_partner (.i_clock(clk), .o_word_sent(ws),
      .o_sent_toggle(st));
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Every wait is bounded, so a stuck handshake ends the run.
   task automatic step(inout int n);
      @(posedge clk);
      n++;
      if (n > 50) begin
         miscompares++;
         summarize();
      end
   endtask : step
   task automatic wr(input logic [31:0] a, v, input logic [3:0] s);
      int n;
      bit ad, wd;
      n = 0;
      ad = 0;
      wd = 0;
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awv <= 1;
      wv <= 1;
      while (!(ad && wd)) begin
         step(n);
         if (!ad && aw_rdy) begin
            ad = 1;
            awv <= 0;
         end
         if (!wd && w_rdy) begin
            wd = 1;
            wv <= 0;
         end
      end
      while (!bv) step(n);
      bready <= 1;
      step(n);
      r = bresp;
      bready <= 0;
   endtask : wr
   task automatic rd(input logic [31:0] a);
      int n;
      n = 0;
      araddr <= a;
      arv <= 1;
      do step(n); while (!ar_rdy);
      arv <= 0;
      while (!rv) step(n);
      rready <= 1;
      step(n);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask : rd
   // ==========================================================
   // Scenarios.
   task automatic t_reset();
      rd(NPTX_ADDR);
      chk("page", 32'h0000_2001, d);
      chk("rresp ok", {30'h0, RESP_OKAY}, {30'h0, r});
      chk("page out", 32'h0000_2001, {16'h0000, page});
      rd(EXP_ADDR);
      chk("expansion", 32'h0000_0004, d);
   endtask : t_reset
   task automatic t_write_all();
      wr(NPTX_ADDR, 32'hFFFF_FFFF, 4'hF);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
      rd(NPTX_ADDR);
      chk("page", 32'h0000_B7FF, d);
      chk("page out", 32'h0000_B7FF, {16'h0000, page});
   endtask : t_write_all
   task automatic t_lanes();
      wr(NPTX_ADDR, 32'h0000_0000, 4'h1);
      rd(NPTX_ADDR);
      chk("low lane", 32'h0000_B700, d);
      wr(NPTX_ADDR, 32'h0000_0000, 4'h2);
      rd(NPTX_ADDR);
      chk("high lane", 32'h0000_0000, d);
   endtask : t_lanes
   task automatic t_toggle();
      u_partner.exchange(1'b0);
      rd(NPTX_ADDR);
      chk("toggle set", 32'h0000_0800, d);
      u_partner.exchange(1'b1);
      // The flip lands on the edge that ends the pulse; look one edge later.
      @(posedge clk);
      chk("toggle out", 32'h0000_0000, {16'h0000, page});
      rd(NPTX_ADDR);
      chk("toggle clear", 32'h0000_0000, d);
   endtask : t_toggle
   task automatic t_unmapped();
      wr(32'h0000_0200, 32'hFFFF_FFFF, 4'hF);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      rd(32'h0000_0200);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("rdata", 32'h0000_0000, d);
   endtask : t_unmapped
   task automatic t_ctrl();
      wr(ARB_ADDR, 32'h0000_0001, 4'h1);
      chk("enable", 32'h0000_0001, {31'h0, en});
      rd(ARB_ADDR);
      chk("ctrl read", 32'h0000_0001, d);
      wr(EXP_ADDR, 32'h0000_0000, 4'hF);
      chk("exp bresp", {30'h0, RESP_OKAY}, {30'h0, r});
      rd(EXP_ADDR);
      chk("exp kept", 32'h0000_0004, d);
      wr(ARB_ADDR, 32'h0000_0000, 4'h1);
      chk("disable", 32'h0000_0000, {31'h0, en});
   endtask : t_ctrl
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      t_reset();
      t_write_all();
      t_lanes();
      t_toggle();
      t_unmapped();
      t_ctrl();
      summarize();
   end
endmodule : np_tx_regs_bench
